// *** test_waveform_dac_sync_trigger.sv ***
module test_waveform_dac_sync_trigger;
  timeunit 1ns;
  timeprecision 100ps;
  import wds_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } wds_row_t;
  logic ref_clk, nrst, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dac_data, q;
  logic [1:0] trigger_input, marker_out;
  logic e;
  int errors, n_tests, w;
  wds_row_t rows [18] = '{
    '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b0, 8'h24, 32'h0, 32'h7},
    '{1'b0, 8'h40, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h2},
    '{1'b1, 8'h24, 32'h0, 32'h0}, '{1'b0, 8'h24, 32'h0, 32'h4},
    '{1'b1, 8'h24, 32'hffff, 32'h0}, '{1'b0, 8'h24, 32'h0, 32'hffff},
    '{1'b1, 8'h28, 32'h0, 32'h0}, '{1'b1, 8'h2c, 32'h1234, 32'h0},
    '{1'b1, 8'h2c, 32'h5678, 32'h0}, '{1'b1, 8'h2c, 32'h9abc, 32'h0},
    '{1'b1, 8'h28, 32'h0, 32'h0}, '{1'b0, 8'h2c, 32'h0, 32'h1234},
    '{1'b0, 8'h2c, 32'h0, 32'h1234}, '{1'b1, 8'h24, 32'h4, 32'h0},
    '{1'b1, 8'h30, 32'h2, 32'h0}, '{1'b1, 8'h08, 32'h1, 32'h0}
  };
  wds_top #(.DEPTH(16), .NCH(2)) i_wds_top (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .trigger_input(trigger_input),
    .marker_out(marker_out), .dac_data(dac_data)
  );
  wds_host i_wds_host (
    .ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wds_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_wds_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(A_TEST);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    chk({31'h0, q[0]}, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Waits for a level on a marker, then counts its length
  task automatic pulse(input int ch, input logic lvl);
    int n;
    n = 0;
    w = 0;
    while (marker_out[ch] !== lvl && n < 600) begin
      @(posedge ref_clk);
      n++;
    end
    while (marker_out[ch] === lvl && w < 600) begin
      @(posedge ref_clk);
      w++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #150us;
    errors++;
    report_and_stop;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    trigger_input = 2'b00;
    errors = 0;
    n_tests = 0;
    tick(3);
    nrst <= 1'b1;
    idle;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a);
        chk(q, rows[i].e);
      end
    end
    rd(A_STAT);
    chk(q & 32'h30, 32'h10);
    rd(8'hfc);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(8'h20, 32'h08);
    wr(8'h34, 32'h1);
    pulse(0, 1'b1);
    chk(32'(w >= TRIG_MIN_CYC && w <= TRIG_MAX_CYC), 32'h1);
    chk({16'h0, dac_data[15:0]}, 32'h1234);
    tick(400);
    chk({31'h0, irq}, 32'h1);
    wr(A_STAT, 32'h3f);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    wr(A_MASK, 32'h0);
    wr(8'h20, 32'h0a);
    wr(8'h34, 32'h1);
    for (int k = 0; k < 4; k++) begin
      pulse(0, 1'b1);
      chk(32'(w), k < 3 ? 32'(UPD_CYC) : 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    wr(8'h20, 32'h0b);
    wr(8'h34, 32'h1);
    tick(50);
    pulse(0, 1'b1);
    chk(32'(w), 32'd600);
    wr(8'h20, 32'h09);
    tick(40);
    wr(8'h34, 32'h1);
    pulse(0, 1'b0);
    chk(32'(w), 32'(LEAD_CYC));
    tick(2);
    chk({16'h0, dac_data[15:0]}, 32'h1234);
    tick(400);
    wr(8'h48, 32'h0);
    wr(8'h4c, 32'hbeef);
    wr(8'h50, 32'h0);
    wr(8'h40, 32'h0c);
    wr(8'h54, 32'h1);
    tick(3);
    chk({16'h0, dac_data[31:16]}, 32'h0);
    trigger_input <= 2'b10;
    tick(2);
    chk({16'h0, dac_data[31:16]}, 32'h0);
    tick(8);
    chk({16'h0, dac_data[31:16]}, 32'hbeef);
    tick(40);
    trigger_input <= 2'b00;
    tick(150);
    wr(A_CTRL, 32'h2);
    idle;
    chk(q, 32'h2);
    wr(8'h28, 32'h0);
    rd(8'h2c);
    chk(q, 32'h0);
    wr(A_CTRL, 32'h1);
    idle;
    rd(8'h40);
    chk(q, 32'h0);
    rd(8'h24);
    chk(q, 32'h7);
    rd(8'h4c);
    chk(q, 32'h0);
    chk(32'(i_wds_host.timeouts), 32'h0);
    report_and_stop;
  end
endmodule

// *** wds_host.sv ***
module wds_host (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  int timeouts;
  initial begin
    timeouts = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ----------------------------------------
  // One bus transfer, held until ready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      timeouts++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** wds_monitor.sv ***
module wds_chk #(
  parameter int NCH = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] marker_out,
  input wire logic [NCH*16-1:0] dac_data
);
  import wds_pkg::*;
  localparam int HOLD_MIN = 5 * TICK_CYC - 1;
  logic [7:0] hi_r [NCH];
  logic [7:0] hi_nxt [NCH];
  logic [7:0] hd_r [NCH];
  logic [7:0] hd_nxt [NCH];
  logic [15:0] dv_r [NCH];
  // ----------------------------------------
  // Saturating high-time and hold-time counters
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      hi_nxt[i] = !marker_out[i] ? 8'h00 :
        hi_r[i] + {7'h00, hi_r[i] != 8'hff};
      hd_nxt[i] = (dac_data[i*16+:16] != dv_r[i]) ? 8'h00 :
        hd_r[i] + {7'h00, hd_r[i] != 8'hff};
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        hi_r[i] <= 8'h00;
        hd_r[i] <= 8'hff;
        dv_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        hi_r[i] <= hi_nxt[i];
        hd_r[i] <= hd_nxt[i];
        dv_r[i] <= dac_data[i*16+:16];
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_first;
    ce && psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_one_wait: assert property (s_first |=> s_answer)
    else $error("access not answered after one wait state");
  a_ready_access: assert property (pready |-> psel && penable
    && $past(psel && penable)) else $error("ready outside access");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("ready without selection");
  a_mk0_width: assert property ($fell(marker_out[0]) |->
    hi_r[0] >= 8'(UPD_CYC)) else $error("marker 0 pulse too short");
  a_mk1_width: assert property ($fell(marker_out[1]) |->
    hi_r[1] >= 8'(UPD_CYC)) else $error("marker 1 pulse too short");
  a_dac0_hold: assert property ($changed(dac_data[15:0]) |->
    hd_r[0] >= 8'(HOLD_MIN)) else $error("point 0 held too briefly");
  a_dac1_hold: assert property ($changed(dac_data[31:16]) |->
    hd_r[1] >= 8'(HOLD_MIN)) else $error("point 1 held too briefly");
endmodule
bind wds_top wds_chk #(.NCH(NCH)) i_wds_chk (
  .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .marker_out(marker_out), .dac_data(dac_data)
);

// *** wds_pkg.sv ***
package wds_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam real TICK_US = 0.25;
  localparam real TRIG_MIN_US = 0.4;
  localparam real TRIG_MAX_US = 0.8;
  localparam real LEAD_US = 4.0;
  localparam real UPD_NS = 350.0;
  localparam int TICK_CYC = int'(TICK_US * CLK_MHZ);
  localparam int TRIG_MIN_CYC = int'($ceil(TRIG_MIN_US * CLK_MHZ));
  localparam int TRIG_MAX_CYC = int'($floor(TRIG_MAX_US * CLK_MHZ));
  localparam int TRIG_CYC = (TRIG_MIN_CYC + TRIG_MAX_CYC) / 2;
  localparam int LEAD_CYC = int'(LEAD_US * CLK_MHZ);
  localparam int UPD_CYC = int'(UPD_NS * CLK_MHZ / 1000.0);
  // Period field holds ticks minus one: 1.25 us .. 16.384 ms
  localparam logic [15:0] PER_MIN = 16'h0004;
  localparam logic [15:0] PER_RST = 16'h0007;
  // ----------------------------------------
  // Memory
  // ----------------------------------------
  localparam int MEM_DEPTH = 32400;
  localparam int WAVE_MAX = 64;
  localparam int NCH = 2;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_TEST = 8'h0c;
  localparam logic [7:0] A_CH0 = 8'h20;
  localparam logic [7:0] A_CHSTEP = 8'h20;
  localparam logic [4:0] O_CFG = 5'h00;
  localparam logic [4:0] O_PER = 5'h04;
  localparam logic [4:0] O_ADR = 5'h08;
  localparam logic [4:0] O_DAT = 5'h0c;
  localparam logic [4:0] O_LEN = 5'h10;
  localparam logic [4:0] O_GO = 5'h14;
  localparam logic [4:0] O_STA = 5'h18;
  localparam int C_RST = 0;
  localparam int C_TEST = 1;
  // Status bits: ch n done = 2n, ch n trigger = 2n+1, test done 4, fail 5
  localparam int S_TDONE = 4;
  localparam int S_TFAIL = 5;
  localparam int NSTAT = 6;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MK_TRIG, MK_WAVE, MK_UPD, MK_HOLD
  } wds_mk_t;
  typedef struct packed {
    logic cont;
    logic arm_source;
    logic external_trigger_source;
    wds_mk_t mode;
  } wds_cfg_t;
  localparam wds_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, MK_TRIG};
endpackage

// *** wds_top.sv ***
// Operation
// - Self-test erases every waveform point in memory.
// - Self-test checks the memory and reports pass or fail status.
// - Per-trigger marker mode gives one pulse of 0.4 to 0.8 us.
// - Per-waveform marker mode drops the marker 4 us before output.
// - Per-update marker mode gives a 350 ns pulse per point update.
// - Held marker mode keeps the marker high.
// - External source starts output from the trigger input.
// - Module reset returns all channel settings to defaults.
// - Both channels carry all marker modes and trigger sources.
// - Memory holds 32400 points per channel for one waveform played from point 0.
// - Point period runs 1.25 us to 16.384 ms in 0.25 us steps.
// - Waveform data is lost on power-up, reset or module reset.
module wds_top #(
  parameter int DEPTH = wds_pkg::MEM_DEPTH,
  parameter int NCH = wds_pkg::NCH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [NCH-1:0] trigger_input,
  output logic [NCH-1:0] marker_out,
  output logic [NCH*16-1:0] dac_data
);
  import wds_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  // ----------------------------------------
  // Storage and shared state
  // ----------------------------------------
  logic [15:0] mem [NCH][DEPTH];
  wds_cfg_t cfg_r [NCH];
  wds_cfg_t cfg_nxt [NCH];
  logic [15:0] per_r [NCH];
  logic [15:0] per_nxt [NCH];
  logic [AW-1:0] adr_r [NCH];
  logic [AW-1:0] adr_nxt [NCH];
  logic [AW-1:0] len_r [NCH];
  logic [AW-1:0] len_nxt [NCH];
  logic [NSTAT-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;
  logic mem_we [NCH];
  logic [AW-1:0] mem_wa [NCH];
  logic [15:0] mem_wd [NCH];
  logic [NCH-1:0] go, ev_done, ev_trig, running;
  logic [AW-1:0] pidx [NCH];
  logic soft_rst;
  logic wr, rd;

  typedef enum {T_IDLE, T_ERASE, T_CHECK} wds_tst_t;
  wds_tst_t tst_r, tst_nxt;
  logic [AW-1:0] ti_r, ti_nxt;
  logic pass_r, pass_nxt, fail_r, fail_nxt, bad_r, bad_nxt;

  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite & ~pready;
  assign soft_rst = wr && paddr == A_CTRL && pwdata[C_RST];

  // ----------------------------------------
  // Self-test and erase sequencer
  // ----------------------------------------
  always_comb begin
    tst_nxt = tst_r;
    ti_nxt = ti_r;
    pass_nxt = pass_r;
    fail_nxt = fail_r;
    bad_nxt = bad_r;
    case (tst_r)
      T_IDLE: begin
        if (soft_rst || (wr && paddr == A_CTRL && pwdata[C_TEST])) begin
          tst_nxt = T_ERASE;
          ti_nxt = '0;
          pass_nxt = 1'b0;
          fail_nxt = 1'b0;
          bad_nxt = 1'b0;
        end
      end
      T_ERASE: begin
        ti_nxt = ti_r + 1'b1;
        if (ti_r == LAST) begin
          tst_nxt = T_CHECK;
          ti_nxt = '0;
        end
      end
      T_CHECK: begin
        for (int c = 0; c < NCH; c++) begin
          if (mem[c][ti_r] != 16'h0000) begin
            bad_nxt = 1'b1;
          end
        end
        ti_nxt = ti_r + 1'b1;
        if (ti_r == LAST) begin
          tst_nxt = T_IDLE;
          pass_nxt = ~bad_nxt;
          fail_nxt = bad_nxt;
        end
      end
      default: tst_nxt = T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tst_r <= T_ERASE;
      ti_r <= '0;
      pass_r <= 1'b0;
      fail_r <= 1'b0;
      bad_r <= 1'b0;
    end else if (ce) begin
      tst_r <= tst_nxt;
      ti_r <= ti_nxt;
      pass_r <= pass_nxt;
      fail_r <= fail_nxt;
      bad_r <= bad_nxt;
    end
  end

  // ----------------------------------------
  // Register file and APB slave
  // ----------------------------------------
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & penable & ~pready;
    go = '0;
    for (int c = 0; c < NCH; c++) begin
      cfg_nxt[c] = cfg_r[c];
      per_nxt[c] = per_r[c];
      adr_nxt[c] = adr_r[c];
      len_nxt[c] = len_r[c];
      mem_we[c] = 1'b0;
      mem_wa[c] = adr_r[c];
      mem_wd[c] = pwdata[15:0];
    end
    if (rd) begin
      case (paddr)
        A_CTRL: prdata_nxt = 32'h0000_0000;
        A_STAT: prdata_nxt = 32'(stat_r);
        A_MASK: prdata_nxt = 32'(mask_r);
        A_TEST: prdata_nxt = {29'h0, fail_r, pass_r, tst_r != T_IDLE};
        default: pslverr_nxt = 1'b1;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (paddr >= A_CH0 + 8'(c) * A_CHSTEP &&
            paddr < A_CH0 + 8'(c + 1) * A_CHSTEP) begin
          pslverr_nxt = 1'b0;
          case (5'(paddr - A_CH0 - 8'(c) * A_CHSTEP))
            O_CFG: prdata_nxt = 32'(cfg_r[c]);
            O_PER: prdata_nxt = 32'(per_r[c]);
            O_ADR: prdata_nxt = 32'(adr_r[c]);
            O_DAT: prdata_nxt = 32'(mem[c][adr_r[c]]);
            O_LEN: prdata_nxt = 32'(len_r[c]);
            O_GO: prdata_nxt = 32'h0000_0000;
            O_STA: prdata_nxt = {15'h0, running[c], 16'(pidx[c])};
            default: pslverr_nxt = 1'b1;
          endcase
        end
      end
    end
    if (wr) begin
      case (paddr)
        A_STAT: stat_nxt = stat_r & ~pwdata[NSTAT-1:0];
        A_MASK: mask_nxt = pwdata[NSTAT-1:0];
        default: ;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (paddr >= A_CH0 + 8'(c) * A_CHSTEP &&
            paddr < A_CH0 + 8'(c + 1) * A_CHSTEP) begin
          case (5'(paddr - A_CH0 - 8'(c) * A_CHSTEP))
            O_CFG: cfg_nxt[c] = wds_cfg_t'(pwdata[4:0]);
            O_PER: per_nxt[c] = pwdata[15:0] < PER_MIN ? PER_MIN
                                : pwdata[15:0];
            O_ADR: adr_nxt[c] = pwdata[AW-1:0] > LAST ? LAST
                                : pwdata[AW-1:0];
            O_DAT: begin
              if (tst_r == T_IDLE) begin
                mem_we[c] = 1'b1;
                adr_nxt[c] = adr_r[c] == LAST ? '0 : adr_r[c] + 1'b1;
              end
            end
            O_LEN: len_nxt[c] = pwdata[AW-1:0] > LAST ? LAST
                                : pwdata[AW-1:0];
            O_GO: go[c] = pwdata[0];
            default: ;
          endcase
        end
      end
    end
    for (int c = 0; c < NCH; c++) begin
      if (tst_r == T_ERASE) begin
        mem_we[c] = 1'b1;
        mem_wa[c] = ti_r;
        mem_wd[c] = 16'h0000;
      end
      if (soft_rst) begin
        cfg_nxt[c] = CFG_RST;
        per_nxt[c] = PER_RST;
        adr_nxt[c] = '0;
        len_nxt[c] = '0;
      end
      // Set wins over a clear in the same cycle
      if (ev_done[c]) stat_nxt[2*c] = 1'b1;
      if (ev_trig[c]) stat_nxt[2*c+1] = 1'b1;
    end
    if (tst_r == T_CHECK && tst_nxt == T_IDLE) begin
      stat_nxt[S_TDONE] = 1'b1;
      stat_nxt[S_TFAIL] = fail_nxt;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= '0;
      mask_r <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= CFG_RST;
        per_r[c] <= PER_RST;
        adr_r[c] <= '0;
        len_r[c] <= '0;
      end
    end else if (ce) begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= cfg_nxt[c];
        per_r[c] <= per_nxt[c];
        adr_r[c] <= adr_nxt[c];
        len_r[c] <= len_nxt[c];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        if (mem_we[c]) mem[c][mem_wa[c]] <= mem_wd[c];
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  typedef enum {P_IDLE, P_LEAD, P_PLAY} wds_ply_t;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wds_ply_t st_r, st_nxt;
    logic s1_r, s2_r, s3_r, edge_det, trig, stop;
    logic [AW-1:0] idx_r, idx_nxt;
    logic [4:0] sub_r, sub_nxt;
    logic [15:0] tk_r, tk_nxt, dac_r, dac_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic mk_nxt, step, load;

    assign edge_det = s2_r & ~s3_r;
    assign stop = soft_rst | (tst_r != T_IDLE);
    assign trig = cfg_r[g].arm_source & ~stop &
                  (cfg_r[g].external_trigger_source ? edge_det
                                                    : go[g]);
    assign step = sub_r == 5'(TICK_CYC - 1) && tk_r == per_r[g];
    assign running[g] = st_r != P_IDLE;
    assign pidx[g] = idx_r;

    always_comb begin
      st_nxt = st_r;
      idx_nxt = idx_r;
      sub_nxt = sub_r;
      tk_nxt = tk_r;
      dac_nxt = dac_r;
      cnt_nxt = cnt_r == '0 ? '0 : cnt_r - 1'b1;
      load = 1'b0;
      ev_done[g] = 1'b0;
      ev_trig[g] = 1'b0;
      case (st_r)
        P_IDLE: begin
          if (trig) begin
            ev_trig[g] = 1'b1;
            idx_nxt = '0;
            if (cfg_r[g].mode == MK_WAVE) begin
              st_nxt = P_LEAD;
              cnt_nxt = 9'(LEAD_CYC - 1);
            end else begin
              st_nxt = P_PLAY;
              load = 1'b1;
              if (cfg_r[g].mode == MK_TRIG) cnt_nxt = 9'(TRIG_CYC);
            end
          end
        end
        P_LEAD: begin
          if (cnt_r == '0) begin
            st_nxt = P_PLAY;
            load = 1'b1;
          end
        end
        P_PLAY: begin
          sub_nxt = sub_r == 5'(TICK_CYC - 1) ? '0 : sub_r + 1'b1;
          if (sub_r == 5'(TICK_CYC - 1)) tk_nxt = tk_r + 1'b1;
          if (step) begin
            tk_nxt = '0;
            if (idx_r == len_r[g]) begin
              ev_done[g] = 1'b1;
              idx_nxt = '0;
              if (cfg_r[g].cont) load = 1'b1;
              else st_nxt = P_IDLE;
            end else begin
              idx_nxt = idx_r + 1'b1;
              load = 1'b1;
            end
          end
        end
        default: st_nxt = P_IDLE;
      endcase
      if (load) begin
        sub_nxt = '0;
        tk_nxt = '0;
        dac_nxt = mem[g][idx_nxt];
        if (cfg_r[g].mode == MK_UPD) cnt_nxt = 9'(UPD_CYC);
      end
      if (stop) begin
        st_nxt = P_IDLE;
        cnt_nxt = '0;
      end
      case (cfg_r[g].mode)
        MK_TRIG: mk_nxt = cnt_nxt != '0;
        MK_WAVE: mk_nxt = st_nxt != P_LEAD;
        MK_UPD: mk_nxt = cnt_nxt != '0;
        MK_HOLD: mk_nxt = 1'b1;
        default: mk_nxt = 1'b0;
      endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        st_r <= P_IDLE;
        idx_r <= '0;
        sub_r <= '0;
        tk_r <= '0;
        dac_r <= 16'h0000;
        cnt_r <= '0;
        marker_out[g] <= 1'b0;
        dac_data[g*16 +: 16] <= 16'h0000;
      end else if (ce) begin
        s1_r <= trigger_input[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        st_r <= st_nxt;
        idx_r <= idx_nxt;
        sub_r <= sub_nxt;
        tk_r <= tk_nxt;
        dac_r <= dac_nxt;
        cnt_r <= cnt_nxt;
        marker_out[g] <= mk_nxt;
        dac_data[g*16 +: 16] <= dac_nxt;
      end
    end
  end
endmodule
